/* hw/mov_map.vh */
// Constants for the memory ordering and visibility block
// Function
// - Release stores and semaphores become visible in one total order for everyone.
// - Own later loads may see own release store before global visibility.
// - Unordered stores are outside the total order; observers may disagree.
// - Fence then unordered store orders locally like a release store.
// - Each processor's accesses keep their ordering constraints in any interleaving.
// - Release store or semaphore stays ahead of causally later stores.
// - Semaphores and release stores become visible everywhere at once.
// - Unordered store may become visible to observers at different times.
// - Acquire load becomes visible before any later access.
// - Both uncacheable attributes mean sequential memory.
// - Sequential accesses reach their peripheral domain in program order.
// - Sequential order holds for acquire, release, fence and unordered alike.
// - Sequential accesses need not be shown to other observers at all.
// - Sequential release access waits until all earlier accesses are visible.
// - Earlier unordered cacheable accesses may become visible in any order.
// - Semaphores never read from nor forward into the local store buffer.
`ifndef MOV_MAP_VH
`define MOV_MAP_VH

// Semantics class carried with each access
`define CLS_W               3
`define CLS_UNORDERED       3'h0
`define CLS_ACQUIRE_LOAD    3'h1
`define CLS_RELEASE_STORE   3'h2
`define CLS_MEMORY_FENCE    3'h3
`define CLS_SEM_ACQUIRE     3'h4
`define CLS_SEM_RELEASE     3'h5

// Page attribute carried with each access
`define ATTR_W                  2
`define ATTR_WRITE_BACK         2'h0
`define ATTR_UNCACHED_STRICT    2'h1
`define ATTR_UNCACHED_EXPORTED  2'h2
`define ATTR_WRITE_COALESCE     2'h3

// Default widths and store buffer depth
`define ADDR_W_DEF          32
`define DATA_W_DEF          64
`define SB_DEPTH_DEF        4
`define TAG_W_DEF           3

`endif

/* hw/store_buffer.v */
// Posted store buffer with address lookup for local load forwarding
`timescale 1ns/1ns
`include "mov_map.vh"
module store_buffer #(
    parameter DEPTH  = `SB_DEPTH_DEF,
    parameter ADDR_W = `ADDR_W_DEF,
    parameter DATA_W = `DATA_W_DEF,
    parameter TAG_W  = `TAG_W_DEF
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              alloc,
    input  wire [ADDR_W-1:0] alloc_addr,
    input  wire [DATA_W-1:0] alloc_data,
    input  wire              free,
    input  wire [TAG_W-1:0]  free_tag,
    input  wire [ADDR_W-1:0] look_addr,
    output reg               hit,
    output reg  [DATA_W-1:0] hit_data,
    output wire              full,
    output wire              empty,
    output reg  [TAG_W-1:0]  free_idx
);
    reg [ADDR_W-1:0] ent_addr [0:DEPTH-1];
    reg [DATA_W-1:0] ent_data [0:DEPTH-1];
    reg [DEPTH-1:0]  ent_valid;
    integer          k;
    integer          j;

    assign full  = &ent_valid;
    assign empty = ~|ent_valid;

    // Lowest free slot; its index is the tag the fabric returns on done
    always @* begin
        free_idx = {TAG_W{1'b0}};
        for (k = DEPTH - 1; k >= 0; k = k - 1) begin
            if (!ent_valid[k]) begin
                free_idx = k[TAG_W-1:0];
            end
        end
    end

    // Stores to a live address are held upstream, so one match at most
    always @* begin
        hit      = 1'b0;
        hit_data = {DATA_W{1'b0}};
        for (j = 0; j < DEPTH; j = j + 1) begin
            if (ent_valid[j] && ent_addr[j] == look_addr) begin
                hit      = 1'b1;
                hit_data = ent_data[j];
            end
        end
    end

    // Each slot fills on allocation and empties when the fabric reports
    // the store visible; slots retire in any order
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : slot
            always @(posedge clk) begin
                if (!rst_n) begin
                    ent_valid[g] <= 1'b0;
                    ent_addr[g]  <= {ADDR_W{1'b0}};
                    ent_data[g]  <= {DATA_W{1'b0}};
                end else if (alloc && free_idx == g) begin
                    ent_valid[g] <= 1'b1;
                    ent_addr[g]  <= alloc_addr;
                    ent_data[g]  <= alloc_data;
                end else if (free && free_tag == g) begin
                    ent_valid[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

/* hw/memory_ordering_visibility.v */
// Ordering and visibility control for the load-store path
`timescale 1ns/1ns
`include "mov_map.vh"
module memory_ordering_visibility #(
    parameter ADDR_W   = `ADDR_W_DEF,
    parameter DATA_W   = `DATA_W_DEF,
    parameter SB_DEPTH = `SB_DEPTH_DEF,
    parameter TAG_W    = `TAG_W_DEF
) (
    input  wire              CORE_CLK,
    input  wire              RST_N,
    // Access stream from the core, in program order
    input  wire              REQ_VALID,
    output reg               REQ_READY,
    input  wire [`CLS_W-1:0] REQ_CLASS,
    input  wire [`ATTR_W-1:0] REQ_ATTR,
    input  wire              REQ_STORE,
    input  wire [ADDR_W-1:0] REQ_ADDR,
    input  wire [DATA_W-1:0] REQ_WDATA,
    output reg               RSP_VALID,
    output reg  [DATA_W-1:0] RSP_DATA,
    output reg               RSP_LOCAL,
    // Coherence domain port
    output reg               COH_VALID,
    input  wire              COH_READY,
    output reg               COH_STORE,
    output reg               COH_GLOBAL,
    output reg               COH_SEM,
    output reg  [TAG_W-1:0]  COH_TAG,
    output reg  [ADDR_W-1:0] COH_ADDR,
    output reg  [DATA_W-1:0] COH_WDATA,
    input  wire              COH_DONE,
    input  wire [TAG_W-1:0]  COH_DONE_TAG,
    input  wire [DATA_W-1:0] COH_RDATA,
    // Peripheral domain port for sequential memory
    output reg               PER_VALID,
    input  wire              PER_READY,
    output reg               PER_STORE,
    output reg  [`CLS_W-1:0] PER_CLASS,
    output reg  [ADDR_W-1:0] PER_ADDR,
    output reg  [DATA_W-1:0] PER_WDATA,
    input  wire              PER_DONE,
    input  wire [DATA_W-1:0] PER_RDATA
);
    // One-hot states
    localparam [5:0] S_IDLE  = 6'h01;
    localparam [5:0] S_CHECK = 6'h02;
    localparam [5:0] S_COH   = 6'h04;
    localparam [5:0] S_WAIT  = 6'h08;
    localparam [5:0] S_PER   = 6'h10;
    localparam [5:0] S_PWAIT = 6'h20;

    // Tag reserved for blocking coherence accesses, past the buffer slots
    localparam [TAG_W-1:0] BLOCK_TAG = SB_DEPTH[TAG_W-1:0];

    // Both uncacheable attributes select sequential memory
    function is_seq;
        input [`ATTR_W-1:0] a;
        begin
            is_seq = (a == `ATTR_UNCACHED_STRICT) ||
                     (a == `ATTR_UNCACHED_EXPORTED);
        end
    endfunction

    function is_sem;
        input [`CLS_W-1:0] c;
        begin
            is_sem = (c == `CLS_SEM_ACQUIRE) || (c == `CLS_SEM_RELEASE);
        end
    endfunction

    reg [5:0]         state;
    reg [`CLS_W-1:0]  cur_cls;
    reg [`ATTR_W-1:0] cur_attr;
    reg               cur_store;
    reg [ADDR_W-1:0]  cur_addr;
    reg [DATA_W-1:0]  cur_wdata;

    wire              sb_hit;
    wire [DATA_W-1:0] sb_hit_data;
    wire              sb_full;
    wire              sb_empty;
    wire [TAG_W-1:0]  sb_free_idx;

    // Decoded view of the held access, tagged by class and attribute
    wire cur_seq  = is_seq(cur_attr);
    wire cur_sem  = is_sem(cur_cls);
    wire cur_fnc  = (cur_cls == `CLS_MEMORY_FENCE);
    wire cur_rel  = (cur_cls == `CLS_RELEASE_STORE) ||
                    (cur_cls == `CLS_SEM_RELEASE);

    // Release, fence and every semaphore wait for all earlier stores to
    // be visible; this keeps a single total order and causal order
    wire need_drain = cur_rel || cur_fnc || cur_sem;

    // Cacheable unordered and release stores are posted; a second store to a live address
    // waits so that same-address updates retire in program order
    wire posted     = cur_store && !cur_sem && !cur_seq && !cur_fnc;
    wire store_hold = posted && (sb_hit || sb_full);

    wire hold       = (need_drain && !sb_empty) || store_hold;

    // Plain and acquire loads may read the own pending store early;
    // semaphores never look into the buffer
    wire fwd_ok = !cur_store && !cur_sem && !cur_seq && !cur_fnc &&
                  sb_hit;

    // Allocation happens at the fabric handshake of a posted store
    wire sb_alloc = (state == S_COH) && COH_READY && posted;
    wire sb_free  = COH_DONE && (COH_DONE_TAG != BLOCK_TAG);

    store_buffer #(
        .DEPTH  (SB_DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .TAG_W  (TAG_W)
    ) u_sb (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .alloc      (sb_alloc),
        .alloc_addr (cur_addr),
        .alloc_data (cur_wdata),
        .free       (sb_free),
        .free_tag   (COH_DONE_TAG),
        .look_addr  (cur_addr),
        .hit        (sb_hit),
        .hit_data   (sb_hit_data),
        .full       (sb_full),
        .empty      (sb_empty),
        .free_idx   (sb_free_idx)
    );

    // Held access, captured when the core hands one over
    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cur_cls   <= `CLS_UNORDERED;
            cur_attr  <= `ATTR_WRITE_BACK;
            cur_store <= 1'b0;
            cur_addr  <= {ADDR_W{1'b0}};
            cur_wdata <= {DATA_W{1'b0}};
        end else if (REQ_VALID && REQ_READY) begin
            cur_cls   <= REQ_CLASS;
            cur_attr  <= REQ_ATTR;
            cur_store <= REQ_STORE;
            cur_addr  <= REQ_ADDR;
            cur_wdata <= REQ_WDATA;
        end
    end

    // Main sequencer. Only one access is held at a time, so program order
    // is kept on each port by construction; loads and semaphores block
    // until their data returns, which costs latency but keeps acquire
    // and sequential ordering trivially correct.
    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state      <= S_IDLE;
            REQ_READY  <= 1'b0;
            RSP_VALID  <= 1'b0;
            RSP_DATA   <= {DATA_W{1'b0}};
            RSP_LOCAL  <= 1'b0;
            COH_VALID  <= 1'b0;
            COH_STORE  <= 1'b0;
            COH_GLOBAL <= 1'b0;
            COH_SEM    <= 1'b0;
            COH_TAG    <= {TAG_W{1'b0}};
            COH_ADDR   <= {ADDR_W{1'b0}};
            COH_WDATA  <= {DATA_W{1'b0}};
            PER_VALID  <= 1'b0;
            PER_STORE  <= 1'b0;
            PER_CLASS  <= `CLS_UNORDERED;
            PER_ADDR   <= {ADDR_W{1'b0}};
            PER_WDATA  <= {DATA_W{1'b0}};
        end else begin
            RSP_VALID <= 1'b0;
            case (state)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        state     <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (!hold) begin
                        if (cur_fnc) begin
                            // Drain done: later accesses now follow
                            RSP_VALID <= 1'b1;
                            RSP_LOCAL <= 1'b0;
                            RSP_DATA  <= {DATA_W{1'b0}};
                            REQ_READY <= 1'b1;
                            state     <= S_IDLE;
                        end else if (cur_seq) begin
                            // Peripheral port only, for every class but the fence
                            PER_VALID <= 1'b1;
                            PER_STORE <= cur_store;
                            PER_CLASS <= cur_cls;
                            PER_ADDR  <= cur_addr;
                            PER_WDATA <= cur_wdata;
                            state     <= S_PER;
                        end else if (fwd_ok) begin
                            RSP_VALID <= 1'b1;
                            RSP_LOCAL <= 1'b1;
                            RSP_DATA  <= sb_hit_data;
                            REQ_READY <= 1'b1;
                            state     <= S_IDLE;
                        end else begin
                            COH_VALID  <= 1'b1;
                            COH_STORE  <= cur_store;
                            // Fabric must make these visible at once
                            COH_GLOBAL <= cur_rel || cur_sem;
                            COH_SEM    <= cur_sem;
                            COH_TAG    <= posted ? sb_free_idx
                                                 : BLOCK_TAG;
                            COH_ADDR   <= cur_addr;
                            COH_WDATA  <= cur_wdata;
                            state      <= S_COH;
                        end
                    end
                end
                S_COH: begin
                    if (COH_READY) begin
                        COH_VALID <= 1'b0;
                        if (posted) begin
                            // Unordered and release stores retire freely
                            RSP_VALID <= 1'b1;
                            RSP_LOCAL <= 1'b0;
                            RSP_DATA  <= {DATA_W{1'b0}};
                            REQ_READY <= 1'b1;
                            state     <= S_IDLE;
                        end else begin
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    // Nothing later is taken before this completes
                    if (COH_DONE && COH_DONE_TAG == BLOCK_TAG) begin
                        RSP_VALID <= 1'b1;
                        RSP_LOCAL <= 1'b0;
                        RSP_DATA  <= COH_RDATA;
                        REQ_READY <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_PER: begin
                    if (PER_READY) begin
                        PER_VALID <= 1'b0;
                        state     <= S_PWAIT;
                    end
                end
                S_PWAIT: begin
                    // Next sequential access waits for this one
                    if (PER_DONE) begin
                        RSP_VALID <= 1'b1;
                        RSP_LOCAL <= 1'b0;
                        RSP_DATA  <= PER_RDATA;
                        REQ_READY <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                default: begin
                    state     <= S_IDLE;
                    REQ_READY <= 1'b0;
                    COH_VALID <= 1'b0;
                    PER_VALID <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* dv/mov_props.sv */
// Port-level ordering checks for the ordering block
`timescale 1ns/1ns
`include "mov_map.vh"
module mov_props #(
    parameter TAG_W = `TAG_W_DEF
) (
    input wire               CORE_CLK,
    input wire               RST_N,
    input wire               REQ_VALID,
    input wire               REQ_READY,
    input wire [`CLS_W-1:0]  REQ_CLASS,
    input wire [`ATTR_W-1:0] REQ_ATTR,
    input wire               RSP_VALID,
    input wire               RSP_LOCAL,
    input wire               COH_VALID,
    input wire               COH_READY,
    input wire               COH_GLOBAL,
    input wire               COH_SEM,
    input wire [TAG_W-1:0]   COH_TAG,
    input wire               COH_DONE,
    input wire [TAG_W-1:0]   COH_DONE_TAG,
    input wire               PER_VALID,
    input wire               PER_READY,
    input wire [`CLS_W-1:0]  PER_CLASS,
    input wire               PER_DONE
);
    reg  [2:0] cls;
    reg        seq;
    reg        busy;
    reg        per_out;
    reg  [2:0] pend;
    wire       up = COH_VALID && COH_READY && COH_TAG < 3'h4;
    wire       dn = COH_DONE && COH_DONE_TAG < 3'h4;

    // Track the access in flight and the posted stores not yet visible
    always @(posedge CORE_CLK) begin
        if (!RST_N) begin
            busy <= 1'b0;
            per_out <= 1'b0;
            pend <= 3'h0;
        end else begin
            if (REQ_VALID && REQ_READY) begin
                busy <= 1'b1;
                cls <= REQ_CLASS;
                seq <= REQ_ATTR[0] ^ REQ_ATTR[1]; // Codes 1 and 2 only
            end else if (RSP_VALID) begin
                busy <= 1'b0;
            end
            if (PER_VALID && PER_READY)
                per_out <= 1'b1;
            else if (PER_DONE)
                per_out <= 1'b0;
            pend <= pend + {2'h0, up} - {2'h0, dn};
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_seq_off_coh: assert property (busy && seq |-> !COH_VALID)
        else $error("sequential access seen on coherence port");
    a_cached_off_per: assert property (busy && !seq |-> !PER_VALID)
        else $error("cacheable access seen on peripheral port");
    a_per_one_out: assert property (per_out |-> !PER_VALID)
        else $error("peripheral access issued before previous done");
    a_sem_global: assert property (COH_VALID && COH_SEM |-> COH_GLOBAL)
        else $error("semaphore not marked global");
    a_sem_no_fwd: assert property (RSP_VALID && busy && cls[2] |-> !RSP_LOCAL)
        else $error("semaphore answered from store buffer");
    a_glob_drained: assert property (COH_VALID && COH_GLOBAL |-> pend == 3'h0)
        else $error("global access issued with stores pending");
    a_per_rel_drained: assert property (PER_VALID && (PER_CLASS ==
        `CLS_RELEASE_STORE || PER_CLASS == `CLS_SEM_RELEASE) |-> pend == 3'h0)
        else $error("sequential release issued with stores pending");
    a_fence_drained: assert property (RSP_VALID && busy &&
        cls == `CLS_MEMORY_FENCE |-> pend == 3'h0)
        else $error("fence completed with stores pending");
    a_acq_after_done: assert property (RSP_VALID && busy && !seq && !RSP_LOCAL
        && cls == `CLS_ACQUIRE_LOAD |-> $past(COH_DONE))
        else $error("acquire load answered before fabric done");

    c_sem: cover property (COH_VALID && COH_SEM);
    c_fwd: cover property (RSP_VALID && RSP_LOCAL);
    c_seq_rel: cover property (PER_VALID && PER_CLASS == `CLS_RELEASE_STORE);
endmodule

bind memory_ordering_visibility mov_props #(.TAG_W(TAG_W)) u_props (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_CLASS(REQ_CLASS), .REQ_ATTR(REQ_ATTR),
    .RSP_VALID(RSP_VALID), .RSP_LOCAL(RSP_LOCAL), .COH_VALID(COH_VALID),
    .COH_READY(COH_READY), .COH_GLOBAL(COH_GLOBAL), .COH_SEM(COH_SEM),
    .COH_TAG(COH_TAG), .COH_DONE(COH_DONE), .COH_DONE_TAG(COH_DONE_TAG),
    .PER_VALID(PER_VALID), .PER_READY(PER_READY), .PER_CLASS(PER_CLASS),
    .PER_DONE(PER_DONE));

/* dv/far_model.sv */
// Far side: coherence fabric and one peripheral domain
`timescale 1ns/1ns
`include "mov_map.vh"
module far_model (
    input  wire        clk,
    input  wire        slow,
    input  wire        coh_valid,
    output reg         coh_ready = 1'b0,
    input  wire [2:0]  coh_tag,
    input  wire [31:0] coh_addr,
    output reg         coh_done = 1'b0,
    output reg  [2:0]  coh_done_tag = 3'h0,
    output reg  [63:0] coh_rdata = 64'h0,
    input  wire        per_valid,
    output reg         per_ready = 1'b0,
    input  wire [2:0]  per_class,
    input  wire [31:0] per_addr,
    output reg         per_done = 1'b0,
    output reg  [63:0] per_rdata = 64'h0
);
    reg [2:0]  tq[$];
    reg [31:0] aq[$];
    reg [31:0] coh_log[$];
    reg [31:0] per_log[$];
    reg        per_early = 1'b0;
    integer    wait_c = 0;
    integer    per_c = 0;

    // Fabric reports visibility in accept order; slow mode stalls long
    always @(posedge clk) begin
        coh_done <= 1'b0;
        coh_rdata <= ~coh_rdata; // Data lines never hold a stale value
        coh_ready <= slow ? ~coh_ready : 1'b1;
        if (coh_valid && coh_ready) begin
            tq.push_back(coh_tag);
            aq.push_back(coh_addr);
        end
        wait_c = (tq.size() > 0) ? wait_c + 1 : 0;
        if (wait_c > (slow ? 20 : 1)) begin
            coh_done <= 1'b1;
            coh_done_tag <= tq.pop_front();
            coh_rdata <= {~aq[0], aq[0]};
            coh_log.push_back(aq.pop_front());
            wait_c = 0;
        end
    end

    // Peripheral answers one access at a time and notes early releases
    always @(posedge clk) begin
        per_done <= 1'b0;
        per_rdata <= ~per_rdata;
        per_ready <= slow ? ~per_ready : 1'b1;
        if (per_c == 1) begin
            per_done <= 1'b1;
            per_rdata <= {~per_log[$], per_log[$]};
        end
        if (per_c > 0)
            per_c = per_c - 1;
        if (per_valid && per_ready) begin
            per_log.push_back(per_addr);
            if (per_class == `CLS_RELEASE_STORE && tq.size() > 0)
                per_early <= 1'b1;
            per_c = slow ? 9 : 2;
        end
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the ordering block
`timescale 1ns/1ns
`include "mov_map.vh"
module tb_top;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_store = 1'b0;
    logic        slow = 1'b0;
    logic [2:0]  req_class = 3'h0;
    logic [1:0]  req_attr = 2'h0;
    logic [31:0] req_addr = 32'h0;
    logic [63:0] req_wdata = 64'h0;
    logic [63:0] got_data;
    logic        got_local;
    integer      fail_count = 0;
    integer      total_checks = 0;
    wire         req_ready, rsp_valid, rsp_local, coh_valid, coh_ready;
    wire         coh_done, per_valid, per_ready, per_done;
    wire         coh_store, coh_global, per_store;
    wire [63:0]  coh_wdata, per_wdata;
    wire [2:0]   coh_tag, coh_done_tag, per_class;
    wire [31:0]  coh_addr, per_addr;
    wire [63:0]  rsp_data, coh_rdata, per_rdata;

    always #4 core_clk = ~core_clk;

    memory_ordering_visibility u_dut (
        .CORE_CLK(core_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_CLASS(req_class), .REQ_ATTR(req_attr),
        .REQ_STORE(req_store), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_LOCAL(rsp_local),
        .COH_VALID(coh_valid), .COH_READY(coh_ready), .COH_STORE(coh_store),
        .COH_GLOBAL(coh_global), .COH_SEM(), .COH_TAG(coh_tag),
        .COH_ADDR(coh_addr), .COH_WDATA(coh_wdata), .COH_DONE(coh_done),
        .COH_DONE_TAG(coh_done_tag), .COH_RDATA(coh_rdata),
        .PER_VALID(per_valid), .PER_READY(per_ready),
        .PER_STORE(per_store), .PER_CLASS(per_class), .PER_ADDR(per_addr),
        .PER_WDATA(per_wdata), .PER_DONE(per_done), .PER_RDATA(per_rdata));

    far_model u_far (
        .clk(core_clk), .slow(slow), .coh_valid(coh_valid),
        .coh_ready(coh_ready), .coh_tag(coh_tag), .coh_addr(coh_addr),
        .coh_done(coh_done), .coh_done_tag(coh_done_tag),
        .coh_rdata(coh_rdata), .per_valid(per_valid), .per_ready(per_ready),
        .per_class(per_class), .per_addr(per_addr), .per_done(per_done),
        .per_rdata(per_rdata));

    // Data the fabric and the peripheral return for any location, whether stored to or not
    function automatic logic [63:0] pat(input logic [31:0] a);
        pat = {~a, a};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks = total_checks + 1;
        if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One access: held until taken, then its answer is captured
    task automatic acc(input logic [2:0] c, input logic [1:0] a,
                       input logic st, input logic [31:0] ad);
        integer n;
        n = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_class <= c;
        req_attr <= a;
        req_store <= st;
        req_addr <= ad;
        req_wdata <= {ad, ~ad}; // Differs from pat so forwarding shows
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (req_ready !== 1'b1 && n < 400);
        req_valid <= 1'b0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (rsp_valid !== 1'b1 && n < 400);
        got_data = rsp_data;
        got_local = rsp_local;
        if (n >= 400) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    endtask

    // Posted stores, a release store, then a fence that drains them all
    task automatic t_release_last;
        integer k;
        slow <= 1'b1;
        k = u_far.coh_log.size();
        acc(`CLS_UNORDERED, `ATTR_WRITE_BACK, 1'b1, 32'h100);
        acc(`CLS_UNORDERED, `ATTR_WRITE_COALESCE, 1'b1, 32'h200);
        acc(`CLS_RELEASE_STORE, `ATTR_WRITE_BACK, 1'b1, 32'h300);
        acc(`CLS_MEMORY_FENCE, `ATTR_WRITE_BACK, 1'b0, 32'h0);
        check(u_far.tq.size(), 0);
        check(u_far.coh_log.size() - k, 3);
        check(u_far.coh_log[k + 2], 32'h300);
    endtask

    // Loads may see own pending store; semaphores never use the buffer
    task automatic t_forward;
        slow <= 1'b1;
        acc(`CLS_UNORDERED, `ATTR_WRITE_BACK, 1'b1, 32'h400);
        acc(`CLS_ACQUIRE_LOAD, `ATTR_WRITE_BACK, 1'b0, 32'h400);
        check(got_local, 1'b1);
        check(got_data, {32'h400, ~32'h400});
        acc(`CLS_SEM_ACQUIRE, `ATTR_WRITE_BACK, 1'b0, 32'h400);
        check(got_local, 1'b0);
        check(got_data, pat(32'h400));
        acc(`CLS_SEM_RELEASE, `ATTR_WRITE_BACK, 1'b1, 32'h500);
        check(coh_store, 1'b1);
        check(coh_global, 1'b1);
        check(coh_wdata, {32'h500, ~32'h500});
        acc(`CLS_UNORDERED, `ATTR_WRITE_BACK, 1'b0, 32'h500);
        check(got_local, 1'b0);
        acc(`CLS_ACQUIRE_LOAD, `ATTR_WRITE_BACK, 1'b0, 32'h700);
        check(got_data, pat(32'h700));
    endtask

    // Unordered, acquire and release accesses to both uncached kinds arrive in program order
    task automatic t_sequential;
        integer k, c0, i;
        slow <= 1'b0;
        k = u_far.per_log.size();
        c0 = u_far.coh_log.size();
        for (i = 0; i < 6; i = i + 1) begin
            acc(3'(i % 3), i < 3 ? `ATTR_UNCACHED_STRICT :
                `ATTR_UNCACHED_EXPORTED, i % 3 != 1, 32'h1000 + 32'(i));
            if (i % 3 == 1)
                check(got_data, pat(32'h1000 + 32'(i)));
        end
        for (i = 0; i < 6; i = i + 1)
            check(u_far.per_log[k + i], 32'h1000 + 32'(i));
        check(u_far.coh_log.size() - c0, 0);
    endtask

    // Sequential release waits behind a slow posted store
    task automatic t_seq_release;
        slow <= 1'b1;
        acc(`CLS_UNORDERED, `ATTR_WRITE_BACK, 1'b1, 32'h600);
        acc(`CLS_RELEASE_STORE, `ATTR_UNCACHED_STRICT, 1'b1, 32'h2000);
        check(u_far.per_early, 1'b0);
        check(u_far.per_log[$], 32'h2000);
        check(per_store, 1'b1);
        check(per_wdata, {32'h2000, ~32'h2000});
    endtask

    // Reset for two cycles, then run each scenario
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_release_last();
        t_forward();
        t_sequential();
        t_seq_release();
        print_verdict();
    end
endmodule
